// ---- hdl/rx_los_and_line_decoder.sv ----
`default_nettype none
module rx_los_and_line_decoder
    import rx_los_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic rec_clk_en,
    input  wire logic rec_pos,
    input  wire logic rec_neg,
    input  wire logic analog_los,
    input  wire logic e3_mode,
    input  wire logic code_select_n,
    input  wire logic ref_clk_in_high,
    input  wire logic ref_clk_in_low,
    output logic      rx_pos_out,
    output logic      rx_neg_out,
    output logic      signal_absent_n,
    output logic [1:0] clk_src_sel
);
    typedef enum logic [0:0] {
        ST_OK   = 1'b0,
        ST_LOSS = 1'b1
    } los_state_t;

    typedef struct packed {
        los_state_t st;
        logic [7:0] zrun;
        logic [7:0] win;
        logic [2:0] zshort;
        logic       pos;
        logic       neg;
        logic       absent_n;
        logic [1:0] src;
    } state_t;
    state_t s_reg, s_next;

    logic sq_pos;
    logic sq_neg;
    logic nrz;
    logic mark;
    logic exz;

    // =========================================================
    // Helpers
    // Counters stop at all ones so that a long zero run cannot wrap round.
    function automatic logic [7:0] inc8_sat(input logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h1;
    endfunction

    // Zeros that must already precede a zero for it to count as excessive.
    function automatic logic [2:0] exz_prior(input logic e3);
        return (e3 ? EXZ_LEN_E3 : EXZ_LEN_T3) - 3'h1;
    endfunction

    // =========================================================
    // Squelch and decoder
    assign sq_pos = rec_pos & ~analog_los;
    assign sq_neg = rec_neg & ~analog_los;
    assign mark   = sq_pos | sq_neg;
    assign exz    = !mark && (s_reg.zshort >= exz_prior(e3_mode));

    zero_sub_decoder u_dec (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .bit_en  (rec_clk_en),
        .e3_mode (e3_mode),
        .pos_in  (sq_pos),
        .neg_in  (sq_neg),
        .nrz_out (nrz)
    );

    // =========================================================
    // Loss detector and output formatter
    always_comb begin
        s_next = s_reg;
        if (rec_clk_en) begin
            s_next.zshort = mark ? 3'h0 : (s_reg.zshort == 3'h7 ? 3'h7 : s_reg.zshort + 3'h1);
            s_next.zrun = mark ? 8'h0 : inc8_sat(s_reg.zrun);
            if (code_select_n) begin
                s_next.pos = sq_pos;
                s_next.neg = sq_neg;
            end else begin
                s_next.pos = nrz;
                s_next.neg = 1'b0;
            end
            unique case (s_reg.st)
                ST_OK: begin
                    s_next.win = 8'h0;
                    if (!mark && inc8_sat(s_reg.zrun) >= LOS_ZERO_RUN) begin
                        s_next.st = ST_LOSS;
                    end
                end
                ST_LOSS: begin
                    if (analog_los || exz) begin
                        s_next.win = 8'h0;
                    end else if (inc8_sat(s_reg.win) >= CLEAR_WINDOW) begin
                        s_next.st  = ST_OK;
                        s_next.win = 8'h0;
                        s_next.zrun = 8'h0;
                    end else begin
                        s_next.win = inc8_sat(s_reg.win);
                    end
                end
            endcase
        end
        // The analog loss is a level, so it restarts the window between strobes too.
        if (s_reg.st == ST_LOSS && analog_los) begin
            s_next.win = 8'h0;
        end
        if (!code_select_n) begin
            s_next.neg = 1'b0;
        end
        s_next.absent_n = (s_next.st != ST_LOSS);
        if (s_next.st == ST_LOSS) begin
            s_next.src = ref_clk_in_low ? CLK_SRC_OSC :
                         ref_clk_in_high ? CLK_SRC_TX : CLK_SRC_REF;
        end else begin
            s_next.src = CLK_SRC_RECOV;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_reg <= '{st: ST_OK, zrun: 8'h0, win: 8'h0, zshort: 3'h0, pos: 1'b0,
                       neg: 1'b0, absent_n: 1'b1, src: CLK_SRC_RECOV};
        end else begin
            s_reg <= s_next;
        end
    end

    assign rx_pos_out      = s_reg.pos;
    assign rx_neg_out      = s_reg.neg;
    assign signal_absent_n = s_reg.absent_n;
    assign clk_src_sel     = s_reg.src;

    // =========================================================
    // Checks
    property p_enter;
        @(posedge ref_clk) disable iff (!rstn)
        (rec_clk_en && !mark && s_reg.zrun == 8'hbf && s_reg.st == ST_OK)
        |=> (s_reg.st == ST_LOSS) ##1 !signal_absent_n;
    endproperty
    a_enter: assert property (p_enter) else $error("loss not entered");

    property p_clear;
        @(posedge ref_clk) disable iff (!rstn)
        (s_reg.st == ST_LOSS && rec_clk_en && !analog_los && !exz && s_reg.win == 8'hbf)
        |=> s_reg.st == ST_OK;
    endproperty
    a_clear: assert property (p_clear) else $error("loss not cleared");

    property p_hold_analog;
        @(posedge ref_clk) disable iff (!rstn)
        (s_reg.st == ST_LOSS && analog_los) |=> s_reg.st == ST_LOSS && s_reg.win == 8'h0;
    endproperty
    a_hold_analog: assert property (p_hold_analog) else $error("window ran");

    property p_flag;
        @(posedge ref_clk) disable iff (!rstn)
        (signal_absent_n != $past(signal_absent_n)) |-> $past(rec_clk_en);
    endproperty
    a_flag: assert property (p_flag) else $error("flag mismatch");

    property p_neg_low;
        @(posedge ref_clk) disable iff (!rstn)
        !code_select_n |=> !rx_neg_out;
    endproperty
    a_neg_low: assert property (p_neg_low) else $error("neg not low");

    property p_squelch;
        @(posedge ref_clk) disable iff (!rstn)
        (code_select_n && analog_los && rec_clk_en) |=> !rx_pos_out && !rx_neg_out;
    endproperty
    a_squelch: assert property (p_squelch) else $error("not squelched");

    property p_bypass;
        @(posedge ref_clk) disable iff (!rstn)
        (code_select_n && rec_clk_en) |=> rx_pos_out == $past(rec_pos && !analog_los);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass wrong");

    property p_src;
        @(posedge ref_clk) disable iff (!rstn)
        (s_next.st == ST_LOSS && ref_clk_in_low) |=> clk_src_sel == CLK_SRC_OSC;
    endproperty
    a_src: assert property (p_src) else $error("clock source wrong");

    property p_no_early;
        @(posedge ref_clk) disable iff (!rstn)
        (s_reg.st == ST_OK && s_reg.zrun < 8'hbf) |=> signal_absent_n;
    endproperty
    a_no_early: assert property (p_no_early) else $error("loss entered early");

    property p_exz;
        @(posedge ref_clk) disable iff (!rstn)
        (s_reg.st == ST_LOSS && rec_clk_en && !mark && s_reg.zshort >= 3'h3)
        |=> s_reg.st == ST_LOSS && s_reg.win == 8'h0;
    endproperty
    a_exz: assert property (p_exz) else $error("zero run ran window");

    property p_src_tx;
        @(posedge ref_clk) disable iff (!rstn)
        (s_next.st == ST_LOSS && !ref_clk_in_low && ref_clk_in_high)
        |=> clk_src_sel == CLK_SRC_TX;
    endproperty
    a_src_tx: assert property (p_src_tx) else $error("transmit source wrong");

    property p_src_ref;
        @(posedge ref_clk) disable iff (!rstn)
        (s_next.st == ST_LOSS && !ref_clk_in_low && !ref_clk_in_high)
        |=> clk_src_sel == CLK_SRC_REF;
    endproperty
    a_src_ref: assert property (p_src_ref) else $error("reference source wrong");

    property p_src_recov;
        @(posedge ref_clk) disable iff (!rstn)
        signal_absent_n |-> clk_src_sel == CLK_SRC_RECOV;
    endproperty
    a_src_recov: assert property (p_src_recov) else $error("source not recovered");

    property p_stand;
        @(posedge ref_clk) disable iff (!rstn)
        !rec_clk_en |=> $stable(rx_pos_out) && $stable(signal_absent_n);
    endproperty
    a_stand: assert property (p_stand) else $error("output moved between strobes");
endmodule // rx_los_and_line_decoder
`default_nettype wire

// ---- hdl/rx_los_pkg.sv ----
// Contract
// - Enter loss state after 192 consecutive zero bits on recovered data.
// - Leave loss state after 192 clock periods with no excessive-zero event.
// - Excessive zero is 3+ zeros in T3/STS-1, 4+ zeros in E3.
// - Loss state shown on active-low output signal_absent_n.
// - Analog loss indication squelches recovered data to zeros.
// - No output reports the analog loss indication.
// - During loss, clock source is oscillator if ref_clk_in_low, else transmit clock if ref_clk_in_high, else reference.
// - Clearing window does not start until analog loss deasserts.
// - code_select_n high passes positive and negative rails through.
// - code_select_n low decodes substitutions and ORs rails onto rx_pos_out.
// - In NRZ mode rx_neg_out is held low.
`default_nettype none
package rx_los_pkg;
    localparam logic [7:0] LOS_ZERO_RUN   = 8'hc0;
    localparam logic [7:0] CLEAR_WINDOW   = 8'hc0;
    localparam logic [2:0] EXZ_LEN_T3     = 3'h3;
    localparam logic [2:0] EXZ_LEN_E3     = 3'h4;
    localparam logic [1:0] CLK_SRC_RECOV  = 2'h0;
    localparam logic [1:0] CLK_SRC_REF    = 2'h1;
    localparam logic [1:0] CLK_SRC_TX     = 2'h2;
    localparam logic [1:0] CLK_SRC_OSC    = 2'h3;
endpackage
`default_nettype wire

// ---- hdl/zero_sub_decoder.sv ----
`default_nettype none
module zero_sub_decoder
    import rx_los_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic bit_en,
    input  wire logic e3_mode,
    input  wire logic pos_in,
    input  wire logic neg_in,
    output logic      nrz_out
);
    typedef struct packed {
        logic [3:0] bits;
        logic [3:0] p;
        logic [3:0] n;
        logic       last_pol;
        logic       have_pol;
    } dec_t;
    dec_t s_reg, s_next;

    // Four-bit delay line; a violation at the newest slot clears the pattern.
    always_comb begin
        logic v;
        v = 1'b0;
        s_next = s_reg;
        if (bit_en) begin
            s_next.bits = {s_reg.bits[2:0], pos_in | neg_in};
            s_next.p    = {s_reg.p[2:0], pos_in};
            s_next.n    = {s_reg.n[2:0], neg_in};
            if (pos_in | neg_in) begin
                // The first mark after reset has nothing to be compared against.
                v = s_reg.have_pol && (pos_in == s_reg.last_pol);
                s_next.last_pol = pos_in;
                s_next.have_pol = 1'b1;
            end
            if (v) begin
                if (e3_mode) begin
                    s_next.bits = 4'h0;
                end else begin
                    s_next.bits[2:0] = 3'h0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign nrz_out = e3_mode ? s_reg.bits[3] : s_reg.bits[2];
endmodule // zero_sub_decoder
`default_nettype wire

// ---- dv/framer_model.sv ----
`default_nettype none
module framer_model (
    input  wire logic        ref_clk,
    input  wire logic        strobe,
    input  wire logic        rx_pos_out,
    output wire logic [15:0] ones_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        took = 1'b0;
    logic [15:0] cnt  = 16'h0;
    // ====================================================
    // Sampling
    // The block launches data on the rising edge, so the framer takes it on the falling one.
    always @(posedge ref_clk) begin
        took <= strobe;
    end
    always @(negedge ref_clk) begin
        if (took && rx_pos_out === 1'b1) begin
            cnt <= cnt + 16'h1;
        end
    end
    assign ones_cnt = cnt;
endmodule // framer_model
`default_nettype wire

// ---- dv/testbench.sv ----
`default_nettype none
module testbench import rx_los_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rstn, rec_clk_en, rec_pos, rec_neg, analog_los, e3_mode;
    logic code_select_n, ref_clk_in_high, ref_clk_in_low;
    logic rx_pos_out, rx_neg_out, signal_absent_n;
    logic [1:0] clk_src_sel;
    logic [15:0] ones_cnt;
    int error_cnt = 0;
    int n_checks = 0;
    rx_los_and_line_decoder i_rx_los_and_line_decoder (.ref_clk(ref_clk), .rstn(rstn),
        .rec_clk_en(rec_clk_en), .rec_pos(rec_pos), .rec_neg(rec_neg),
        .analog_los(analog_los), .e3_mode(e3_mode), .code_select_n(code_select_n),
        .ref_clk_in_high(ref_clk_in_high), .ref_clk_in_low(ref_clk_in_low),
        .rx_pos_out(rx_pos_out), .rx_neg_out(rx_neg_out),
        .signal_absent_n(signal_absent_n), .clk_src_sel(clk_src_sel));
    framer_model i_framer_model (.ref_clk(ref_clk), .strobe(rec_clk_en),
        .rx_pos_out(rx_pos_out), .ones_cnt(ones_cnt));
    // ====================================================
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic strobe(input logic p, input logic n);
        @(posedge ref_clk);
        #1 rec_clk_en = 1'b1; rec_pos = p; rec_neg = n;
        @(posedge ref_clk);
        #1 rec_clk_en = 1'b0;
    endtask
    task automatic zeros(input int cnt);
        repeat (cnt) strobe(1'b0, 1'b0);
    endtask
    task automatic marks(input int pairs);
        repeat (pairs) begin
            strobe(1'b1, 1'b0);
            strobe(1'b0, 1'b1);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ====================================================
    // Scenarios
    task automatic t_bypass();
        code_select_n = 1'b1;
        strobe(1'b1, 1'b0);
        check(rx_pos_out, 1'b1);
        check(rx_neg_out, 1'b0);
        strobe(1'b0, 1'b1);
        check(rx_pos_out, 1'b0);
        check(rx_neg_out, 1'b1);
        analog_los = 1'b1;
        strobe(1'b1, 1'b0);
        check(rx_pos_out, 1'b0);
        strobe(1'b0, 1'b1);
        check(rx_neg_out, 1'b0);
        check(signal_absent_n, 1'b1);
        analog_los = 1'b0;
    endtask
    // Each pair of bits is one slot: 10 positive mark, 01 negative mark.
    task automatic t_nrz(input logic e3, input logic [11:0] pat);
        logic [15:0] c;
        code_select_n = 1'b0;
        e3_mode = e3;
        zeros(6);
        c = ones_cnt;
        for (int i = 5; i >= 0; i--) begin
            strobe(pat[2*i+1], pat[2*i]);
            check(rx_neg_out, 1'b0);
        end
        zeros(6);
        check(ones_cnt - c, 16'h2);
    endtask
    task automatic t_loss();
        logic [1:0] want [3] = '{CLK_SRC_REF, CLK_SRC_TX, CLK_SRC_OSC};
        code_select_n = 1'b1;
        e3_mode = 1'b0;
        strobe(1'b1, 1'b0);
        zeros(191);
        check(signal_absent_n, 1'b1);
        zeros(1);
        @(posedge ref_clk);
        #1 check(signal_absent_n, 1'b0);
        for (int i = 0; i < 3; i++) begin
            ref_clk_in_high = (i == 1);
            ref_clk_in_low = (i == 2);
            repeat (2) @(posedge ref_clk);
            #1 check(clk_src_sel, want[i]);
        end
        analog_los = 1'b1;
        marks(100);
        check(rx_neg_out, 1'b0);
        check(signal_absent_n, 1'b0);
        analog_los = 1'b0;
        zeros(200);
        check(signal_absent_n, 1'b0);
        marks(75);
        zeros(3);
        marks(50);
        check(signal_absent_n, 1'b0);
        marks(47);
        @(posedge ref_clk);
        #1 check(signal_absent_n, 1'b1);
        check(clk_src_sel, CLK_SRC_RECOV);
    endtask
    // In E3 three zeros are harmless and four restart the window of 192 strobes.
    task automatic t_loss_e3();
        e3_mode = 1'b1;
        zeros(192);
        @(posedge ref_clk);
        #1 check(signal_absent_n, 1'b0);
        marks(50);
        zeros(4);
        marks(50);
        zeros(3);
        marks(44);
        check(signal_absent_n, 1'b0);
        strobe(1'b1, 1'b0);
        check(signal_absent_n, 1'b1);
    endtask
    // ====================================================
    // Run
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (10000) @(posedge ref_clk);
        error_cnt++;
        final_report();
    end
    initial begin
        {rstn, rec_clk_en, rec_pos, rec_neg, analog_los, e3_mode} = 6'h0;
        {code_select_n, ref_clk_in_high, ref_clk_in_low} = 3'h4;
        repeat (6) @(posedge ref_clk);
        #1 rstn = 1'b1;
        check(signal_absent_n, 1'b1);
        check(rx_pos_out, 1'b0);
        check(rx_neg_out, 1'b0);
        check(clk_src_sel, CLK_SRC_RECOV);
        t_bypass();
        t_nrz(1'b0, 12'b00_10_01_10_00_10);
        t_nrz(1'b1, 12'b01_10_00_00_00_10);
        t_loss();
        t_loss_e3();
        final_report();
    end
endmodule // testbench
`default_nettype wire
